// *** logic/ssd_pkg.sv ***
// Package for the serial diagnostic status logic of a safety sensor.
// Assumes a 100 MHz core clock shared by the sensor end and the controller end.
package ssd_pkg;
    // ==========================================================
    // Timing.
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned DISCREP_MS = 500;
    localparam int unsigned DISCREP_CYC = DISCREP_MS * 1000 * CLK_MHZ;
    localparam longint unsigned WARN_MIN = 30;
    localparam longint unsigned WARN_CYC = WARN_MIN * 60 * 1000 * 1000 * CLK_MHZ;
    localparam int unsigned FLASH5_HZ = 5;
    localparam int unsigned FLASH5_HALF_CYC = CLK_MHZ * 1000000 / (2 * FLASH5_HZ);
    localparam int CNT_W = 40;
    // ==========================================================
    // Request byte bits.
    localparam int REQ_DISC_ACK = 6;
    localparam int REQ_ERR_RESET = 7;
    // Response byte bits.
    localparam int RSP_OUT_ON = 0;
    localparam int RSP_ACTUATOR = 1;
    localparam int RSP_FEEDBACK_OPEN = 3;
    localparam int RSP_INPUTS = 4;
    localparam int RSP_LIMIT = 5;
    localparam int RSP_WARNING = 6;
    localparam int RSP_ERROR = 7;
    // Diagnostic byte bits.
    localparam int DG_OUT_A = 0;
    localparam int DG_OUT_B = 1;
    localparam int DG_CROSS = 2;
    localparam int DG_TEMP = 3;
    localparam int DG_ACTUATOR = 4;
    localparam int DG_INTERNAL = 5;
    localparam int DG_WARN_COMM = 6;
    localparam int DG_DISCREP = 6;
    // Wishbone register offsets and request reset value of the controller end.
    localparam logic [3:0] ADR_REQUEST = 4'h0;
    localparam logic [3:0] ADR_RESPONSE = 4'h4;
    localparam logic [3:0] ADR_DIAG = 4'h8;
    localparam logic [3:0] ADR_STATUS = 4'hc;
    localparam logic [7:0] REQ_RESET_VAL = 8'h00;
endpackage : ssd_pkg

// *** logic/ssd_link_if.sv ***
// Interface carrying the three diagnostic bytes between sensor and controller.
// Assumes both ends run on the same clock; bytes are levels refreshed continuously.
`timescale 1ns/100ps
interface ssd_link_if;
    logic [7:0] request_byte;
    logic [7:0] response_byte;
    logic [7:0] warning_error_byte;
    logic comm_ok;
    modport sensor (input request_byte, output response_byte, output warning_error_byte,
        output comm_ok);
    modport ctrl (output request_byte, input response_byte, input warning_error_byte,
        input comm_ok);
endinterface : ssd_link_if

// *** logic/ssd_sync.sv ***
// Three-stage input synchroniser with agreement of stages two and three.
// Assumes the input is asynchronous to core_clk_i.
`timescale 1ns/100ps
module ssd_sync (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    typedef struct packed {
        logic [2:0] sh;
        logic q;
    } ssd_sync_type;
    ssd_sync_type s_reg, s_next;

    // ==========================================================
    // Stage one feeds only stage two; the output moves when two and three agree.
    always_comb begin
        s_next = s_reg;
        s_next.sh = {s_reg.sh[1:0], d_i};
        if (s_reg.sh[1] == s_reg.sh[2]) begin
            s_next.q = s_reg.sh[2];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q_o = s_reg.q;
endmodule : ssd_sync

// *** logic/ssd_sensor.sv ***
// Sensor end: builds response and diagnostic bytes and controls the safety outputs.
// Assumes pin inputs are asynchronous; fault causes come from monitoring logic outside.
// Function
// - Response bits 0,1,4,5 show live state
// - Bit 6 warning pending, bit 7 error
// - Warning byte flags output, cross, temp, comm
// - Error byte flags actuator, internal, discrepancy
// - Request bit 7 resets, bit 6 acknowledges
// - Diagnostic byte valid when warning/error shown
// - Request inbound, response and diagnostic outbound
// - Feedback open sets bit 3, clears bit 0
// - Power-up feedback open: outputs off, 5 Hz
// - Level variant enables on feedback closure
// - Edge variant enables on feedback falling edge
// - Inputs differing over 500 ms latch error
// - Discrepancy error kept across power loss
// - No re-enable until discrepancy acknowledged
// - Acknowledge by button fall or request
// - Internal error clears on bit7 fall or guard open
// - Warning for 30 minutes switches outputs off
// - Comm failure holds outputs unchanged
`timescale 1ns/100ps
module ssd_sensor #(
    parameter longint unsigned WARN_CYC = ssd_pkg::WARN_CYC,
    parameter int unsigned DISCREP_CYC = ssd_pkg::DISCREP_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    ssd_link_if.sensor link,
    input wire logic edge_restart_variant_i,
    input wire logic estop_monitor_i,
    input wire logic actuator_i,
    input wire logic limit_area_i,
    input wire logic safety_input_a_i,
    input wire logic safety_input_b_i,
    input wire logic feedback_closed_i,
    input wire logic ack_button_i,
    input wire logic comm_ok_i,
    input wire logic fault_out_a_i,
    input wire logic fault_out_b_i,
    input wire logic fault_cross_i,
    input wire logic fault_temp_i,
    input wire logic fault_actuator_i,
    input wire logic fault_internal_i,
    input wire logic discrep_saved_i,
    output logic discrep_saved_o,
    output logic safety_output_a_o,
    output logic safety_output_b_o,
    output logic yellow_led_o
);
    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_ON = 3'b010,
        ST_OFF = 3'b100
    } ssd_out_type;

    typedef struct packed {
        ssd_out_type st;
        logic [7:0] req_prev;
        logic fb_prev;
        logic ack_prev;
        logic boot;
        logic discrep_err;
        logic internal_err;
        logic [ssd_pkg::CNT_W-1:0] warn_cnt;
        logic [ssd_pkg::CNT_W-1:0] disc_cnt;
        logic [ssd_pkg::CNT_W-1:0] flash_cnt;
        logic flash;
        logic [7:0] rsp;
        logic [7:0] diag;
    } ssd_sensor_type;
    ssd_sensor_type s_reg, s_next;

    logic in_a, in_b, fb, ack_btn, actuated, limit;
    ssd_sync u_sa (.core_clk_i(core_clk_i), .rst_i(rst_i), .d_i(safety_input_a_i), .q_o(in_a));
    ssd_sync u_sb (.core_clk_i(core_clk_i), .rst_i(rst_i), .d_i(safety_input_b_i), .q_o(in_b));
    ssd_sync u_fb (.core_clk_i(core_clk_i), .rst_i(rst_i), .d_i(feedback_closed_i), .q_o(fb));
    ssd_sync u_ak (.core_clk_i(core_clk_i), .rst_i(rst_i), .d_i(ack_button_i), .q_o(ack_btn));
    ssd_sync u_ac (.core_clk_i(core_clk_i), .rst_i(rst_i), .d_i(actuator_i), .q_o(actuated));
    ssd_sync u_lm (.core_clk_i(core_clk_i), .rst_i(rst_i), .d_i(limit_area_i), .q_o(limit));

    logic warn_held, warn_any, err_any, bit7_fall, ack_fall, restart, disc_ack;
    logic [ssd_pkg::CNT_W-1:0] warn_lim, disc_lim;

    // ==========================================================
    // Next-state logic for restart, errors, counters and the two bytes.
    always_comb begin
        s_next = s_reg;
        warn_lim = ssd_pkg::CNT_W'(WARN_CYC);
        disc_lim = ssd_pkg::CNT_W'(DISCREP_CYC);
        s_next.req_prev = comm_ok_i ? link.request_byte : s_reg.req_prev;
        s_next.fb_prev = fb;
        s_next.ack_prev = ack_btn;
        s_next.boot = 1'b0;
        // Captured one cycle after reset so the strap is never read under reset.
        if (s_reg.boot) begin
            s_next.discrep_err = discrep_saved_i;
        end
        bit7_fall = comm_ok_i && s_reg.req_prev[ssd_pkg::REQ_ERR_RESET]
            && !link.request_byte[ssd_pkg::REQ_ERR_RESET];
        disc_ack = comm_ok_i && link.request_byte[ssd_pkg::REQ_DISC_ACK]
            && !s_reg.req_prev[ssd_pkg::REQ_DISC_ACK];
        ack_fall = s_reg.ack_prev && !ack_btn;
        warn_held = fault_out_a_i || fault_out_b_i || fault_cross_i || fault_temp_i;
        warn_any = warn_held || !comm_ok_i;
        // Internal error latches; clears only after cause is gone. Set wins.
        if (fault_internal_i) begin
            s_next.internal_err = 1'b1;
        end else if (bit7_fall || !actuated) begin
            s_next.internal_err = 1'b0;
        end
        // Discrepancy timer runs while monitoring and the inputs differ.
        if (estop_monitor_i && (in_a != in_b)) begin
            if (s_reg.disc_cnt < disc_lim) begin
                s_next.disc_cnt = s_reg.disc_cnt + 1'b1;
            end
        end else begin
            s_next.disc_cnt = '0;
        end
        if (estop_monitor_i && s_reg.disc_cnt >= disc_lim) begin
            s_next.discrep_err = 1'b1;
        end else if (ack_fall || disc_ack) begin
            s_next.discrep_err = 1'b0;
        end
        // Warnings held continuously count toward forced shutdown. A lost link is left
        // out, so a dead gateway alone can never switch the outputs off.
        if (warn_held) begin
            if (s_reg.warn_cnt < warn_lim) begin
                s_next.warn_cnt = s_reg.warn_cnt + 1'b1;
            end
        end else begin
            s_next.warn_cnt = '0;
        end
        err_any = s_reg.internal_err || fault_internal_i || s_reg.discrep_err
            || fault_actuator_i || (s_reg.warn_cnt >= warn_lim);
        restart = edge_restart_variant_i ? (s_reg.fb_prev && !fb) : fb;
        unique case (s_reg.st)
            ST_WAIT: begin
                if (err_any || !actuated || !(in_a && in_b)) begin
                    s_next.st = ST_OFF;
                end else if (restart && comm_ok_i) begin
                    // Enabling waits for the link, so a lost link holds the outputs off.
                    s_next.st = ST_ON;
                end
            end
            ST_ON: begin
                // A lost link alone never switches the outputs.
                if (err_any || !actuated || !(in_a && in_b)) begin
                    s_next.st = ST_OFF;
                end
            end
            ST_OFF: begin
                if (!err_any && actuated && in_a && in_b) begin
                    s_next.st = ST_WAIT;
                end
            end
        endcase
        // Free-running 5 Hz flasher.
        if (s_reg.flash_cnt >= ssd_pkg::CNT_W'(ssd_pkg::FLASH5_HALF_CYC - 1)) begin
            s_next.flash_cnt = '0;
            s_next.flash = !s_reg.flash;
        end else begin
            s_next.flash_cnt = s_reg.flash_cnt + 1'b1;
        end
        s_next.rsp = '0;
        // Built from the next state so the byte moves in the same cycle as the outputs.
        s_next.rsp[ssd_pkg::RSP_OUT_ON] = (s_next.st == ST_ON);
        s_next.rsp[ssd_pkg::RSP_ACTUATOR] = actuated;
        s_next.rsp[ssd_pkg::RSP_FEEDBACK_OPEN] = (s_next.st == ST_WAIT);
        s_next.rsp[ssd_pkg::RSP_INPUTS] = in_a && in_b;
        s_next.rsp[ssd_pkg::RSP_LIMIT] = limit && actuated;
        s_next.rsp[ssd_pkg::RSP_WARNING] = warn_any || err_any;
        s_next.rsp[ssd_pkg::RSP_ERROR] = err_any;
        s_next.diag = '0;
        s_next.diag[ssd_pkg::DG_OUT_A] = fault_out_a_i;
        s_next.diag[ssd_pkg::DG_OUT_B] = fault_out_b_i;
        s_next.diag[ssd_pkg::DG_CROSS] = fault_cross_i;
        s_next.diag[ssd_pkg::DG_TEMP] = fault_temp_i;
        if (err_any) begin
            s_next.diag[ssd_pkg::DG_ACTUATOR] = fault_actuator_i;
            s_next.diag[ssd_pkg::DG_INTERNAL] = s_reg.internal_err || fault_internal_i;
            s_next.diag[ssd_pkg::DG_DISCREP] = s_reg.discrep_err;
        end else begin
            s_next.diag[ssd_pkg::DG_INTERNAL] = fault_internal_i;
            s_next.diag[ssd_pkg::DG_WARN_COMM] = !comm_ok_i;
        end
    end

    // ==========================================================
    // State register; power-up lands in the wait state with outputs off.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '{st: ST_WAIT, boot: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs; the link bytes flow outward only.
    assign link.response_byte = s_reg.rsp;
    assign link.warning_error_byte = s_reg.diag;
    assign link.comm_ok = comm_ok_i;
    assign discrep_saved_o = s_reg.discrep_err;
    assign safety_output_a_o = (s_reg.st == ST_ON);
    assign safety_output_b_o = (s_reg.st == ST_ON);
    assign yellow_led_o = (s_reg.st == ST_WAIT) ? s_reg.flash : actuated;
endmodule : ssd_sensor

// *** logic/ssd_ctrl.sv ***
// Controller end: Wishbone slave holding the request byte and mirroring sensor bytes.
// Assumes classic Wishbone single cycles on core_clk_i.
`timescale 1ns/100ps
module ssd_ctrl (
    input wire logic core_clk_i,
    input wire logic rst_i,
    ssd_link_if.ctrl link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef struct packed {
        logic [7:0] req;
        logic [31:0] dat;
        logic ack;
    } ssd_ctrl_type;
    ssd_ctrl_type s_reg, s_next;

    // ==========================================================
    // One-wait-state slave: ack one cycle after the request, dropped next.
    always_comb begin
        s_next = s_reg;
        s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
        s_next.dat = '0;
        // The write lands at the edge where the master samples ack high.
        if (wb_cyc_i && wb_stb_i && s_reg.ack && wb_we_i) begin
            if (wb_adr_i == ssd_pkg::ADR_REQUEST && wb_sel_i[0]) begin
                s_next.req = wb_dat_i[7:0];
            end
        end
        if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
            unique case (wb_adr_i)
                ssd_pkg::ADR_REQUEST: s_next.dat = {24'h000000, s_reg.req};
                ssd_pkg::ADR_RESPONSE: s_next.dat = {24'h000000, link.response_byte};
                ssd_pkg::ADR_DIAG: s_next.dat = {24'h000000, link.warning_error_byte};
                ssd_pkg::ADR_STATUS: s_next.dat = {31'h00000000, link.comm_ok};
                default: s_next.dat = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '{req: ssd_pkg::REQ_RESET_VAL, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.request_byte = s_reg.req;
    assign wb_dat_o = s_reg.dat;
    assign wb_ack_o = s_reg.ack;
endmodule : ssd_ctrl

// *** sim/ssd_link_assertions.sv ***
// Checker for the diagnostic link joining the sensor end and the controller end.
// Assumes one clock domain and sees only the link signals as plain inputs.
`timescale 1ns/100ps
module ssd_link_assertions (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] request_byte,
    input wire logic [7:0] response_byte,
    input wire logic [7:0] warning_error_byte,
    input wire logic comm_ok
);
    // ====================================
    // Properties on the response and diagnostic bytes and on comm_ok.
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Loss of the gateway link must show as a warning within the byte latency.
    sequence s_link_lost;
        $fell(comm_ok);
    endsequence
    sequence s_warn_up;
        ##[1:4] response_byte[6];
    endsequence
    AST_RSP_UNUSED_ZERO: assert property (response_byte[2] == 1'h0)
        else $error("response bit 2 set");
    AST_DIAG_TOP_ZERO: assert property (warning_error_byte[7] == 1'h0)
        else $error("diagnostic bit 7 set");
    AST_OPEN_MEANS_OFF: assert property (response_byte[3] |-> !response_byte[0])
        else $error("outputs on while feedback open");
    AST_ERROR_MEANS_OFF: assert property (response_byte[7] |-> !response_byte[0])
        else $error("outputs on during error");
    AST_ON_NEEDS_ACTUATOR: assert property ($rose(response_byte[0]) |->
        response_byte[1] && response_byte[4])
        else $error("outputs enabled without actuator and inputs");
    AST_CLEAN_DIAG: assert property (!response_byte[6] && !response_byte[7] |->
        warning_error_byte == 8'h00)
        else $error("diagnostic byte set without warning or error");
    AST_COMM_WARN: assert property (s_link_lost |-> s_warn_up)
        else $error("link loss not reported as warning");
    AST_COMM_HOLD: assert property (!comm_ok && !$past(comm_ok) |->
        !$rose(response_byte[0]))
        else $error("outputs switched on while link lost");
endmodule : ssd_link_assertions

// *** sim/testbench.sv ***
// Testbench joining both design ends over the link interface, driving Wishbone.
// Assumes shortened warning and discrepancy counts, given as parameters below.
`timescale 1ns/100ps
module testbench;
    localparam int unsigned WARN = 100;
    localparam int unsigned DISC = 50;
    logic core_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [3:0] warn_f = 4'h0;
    logic [31:0] wdat = 32'h0, rd, rdat;
    logic edge_v = 1'h0, estop = 1'h0, act = 1'h1, limit = 1'h0, in_a = 1'h1, in_b = 1'h1;
    logic fb = 1'h0, ack_btn = 1'h0, comm = 1'h1, f_act = 1'h0, f_int = 1'h0, nv = 1'h0;
    logic saved, out_a, out_b, led;
    int fail_count = 0, n_tests = 0, cycles = 0;
    // ====================================
    // Clock, the two ends and the checker.
    always #5 core_clk_i = ~core_clk_i;
    ssd_link_if link ();
    ssd_sensor #(.WARN_CYC(WARN), .DISCREP_CYC(DISC)) ssd_sensor_inst (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .link(link), .edge_restart_variant_i(edge_v), .estop_monitor_i(estop),
        .actuator_i(act), .limit_area_i(limit), .safety_input_a_i(in_a),
        .safety_input_b_i(in_b), .feedback_closed_i(fb), .ack_button_i(ack_btn),
        .comm_ok_i(comm), .fault_out_a_i(warn_f[0]), .fault_out_b_i(warn_f[1]),
        .fault_cross_i(warn_f[2]), .fault_temp_i(warn_f[3]), .fault_actuator_i(f_act),
        .fault_internal_i(f_int), .discrep_saved_i(nv), .discrep_saved_o(saved),
        .safety_output_a_o(out_a), .safety_output_b_o(out_b), .yellow_led_o(led));
    ssd_ctrl ssd_ctrl_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(link),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    ssd_link_assertions ssd_link_assertions_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .request_byte(link.request_byte), .response_byte(link.response_byte),
        .warning_error_byte(link.warning_error_byte), .comm_ok(link.comm_ok));
    // ====================================
    // Tasks; the leading edge wait keeps one idle cycle between bus cycles.
    task automatic stop_test();
        $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : wt
    // Waits for ack without a limit of its own; the hang guard ends a stuck cycle.
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s = 4'hf);
        @(posedge core_clk_i);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, s, d};
        do begin
            @(posedge core_clk_i);
        end while (ack !== 1'h1);
        rd = rdat;
        {cyc, stb, we} <= 3'h0;
    endtask : wb
    task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        wb(a, 1'h0, 32'h0);
        check(rd & {24'hffffff, m}, {24'h0, e});
    endtask : rc
    // Open then close the feedback circuit; a level restart needs the closure.
    task automatic restart();
        fb <= 1'h0;
        wt(8);
        fb <= 1'h1;
        wt(8);
    endtask : restart
    task automatic pwr();
        rst_i <= 1'h1;
        wt(10);
        rst_i <= 1'h0;
        wt(8);
    endtask : pwr
    // Hang guard, far above the several hundred cycles the sequence needs.
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // ====================================
    // Main sequence.
    initial begin
        wt(10);
        rst_i <= 1'h0;
        wt(8);
        rc(4'h4, 8'hff, 8'h1a);
        check({out_a, out_b}, 2'h0);
        check(led, 1'h0);
        fb <= 1'h1;
        wt(8);
        rc(4'h4, 8'hff, 8'h13);
        check({out_a, out_b, led}, 3'h7);
        limit <= 1'h1;
        wt(8);
        rc(4'h4, 8'hff, 8'h33);
        limit <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            warn_f <= 4'h1 << i;
            wt(6);
            rc(4'h4, 8'hff, 8'h53);
            rc(4'h8, 8'hff, 8'h01 << i);
            warn_f <= 4'h0;
            wt(6);
            rc(4'h8, 8'hff, 8'h00);
        end
        comm <= 1'h0;
        wt(6);
        rc(4'h8, 8'hff, 8'h40);
        rc(4'h4, 8'h41, 8'h41);
        rc(4'hc, 8'h01, 8'h00);
        comm <= 1'h1;
        wt(6);
        rc(4'hc, 8'h01, 8'h01);
        rc(4'h4, 8'hff, 8'h13);
        warn_f <= 4'h8;
        wt(WARN + 10);
        rc(4'h4, 8'h41, 8'h40);
        warn_f <= 4'h0;
        restart();
        wb(4'h4, 1'h1, 32'hff);
        rc(4'h4, 8'hff, 8'h13);
        rc(4'h2, 8'hff, 8'h00);
        wb(4'h0, 1'h1, 32'h80, 4'h0);
        rc(4'h0, 8'hff, 8'h00);
        f_int <= 1'h1;
        wt(6);
        rc(4'h4, 8'h81, 8'h80);
        rc(4'h8, 8'hff, 8'h20);
        f_int <= 1'h0;
        wb(4'h0, 1'h1, 32'h80);
        wt(6);
        rc(4'h0, 8'hff, 8'h80);
        rc(4'h4, 8'h80, 8'h80);
        wb(4'h0, 1'h1, 32'h00);
        wt(6);
        rc(4'h4, 8'h80, 8'h00);
        restart();
        estop <= 1'h1;
        in_a <= 1'h0;
        wt(DISC + 20);
        rc(4'h8, 8'hff, 8'h40);
        check({saved, out_a}, 2'h2);
        in_a <= 1'h1;
        restart();
        check(out_a, 1'h0);
        wb(4'h0, 1'h1, 32'h40);
        wt(6);
        rc(4'h4, 8'h80, 8'h00);
        restart();
        check(out_a, 1'h1);
        wb(4'h0, 1'h1, 32'h00);
        in_a <= 1'h0;
        wt(DISC + 20);
        in_a <= 1'h1;
        nv <= saved;
        pwr();
        rc(4'h4, 8'h80, 8'h80);
        ack_btn <= 1'h1;
        wt(8);
        ack_btn <= 1'h0;
        wt(8);
        rc(4'h4, 8'h80, 8'h00);
        {estop, nv, edge_v} <= 3'h1;
        pwr();
        wt(8);
        check(out_b, 1'h0);
        fb <= 1'h0;
        wt(8);
        check(out_b, 1'h1);
        stop_test();
    end
endmodule : testbench
